// file: design/sound_pwm_pkg.sv
// package: register map, field layout and constants of the pwm sound stage
package sound_pwm_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] off_clock_control = 8'h00;
    localparam logic [7:0] off_control       = 8'h04;
    localparam logic [7:0] off_sample0       = 8'h08;
    localparam logic [7:0] off_sample1       = 8'h0c;
    localparam logic [7:0] off_irq_flags     = 8'h10;
    localparam logic [7:0] off_irq_enable    = 8'h14;
    localparam logic [7:0] off_mode          = 8'h18;
    localparam logic [7:0] off_proc_control  = 8'h1c;
    localparam logic [7:0] off_proc_command  = 8'h20;
    localparam logic [7:0] off_proc_state    = 8'h24;
    localparam logic [7:0] off_speed_pitch   = 8'h28;

    // ==========================================================
    // field positions
    localparam int pos_debug_run     = 8;
    localparam int pos_clock_divide_select        = 4;
    localparam int pos_clock_source_select        = 0;
    localparam int pos_output_enable = 0;
    localparam int pos_rate          = 1;
    localparam int pos_resamp_en     = 12;
    localparam int pos_tone_on       = 13;
    localparam int pos_pwm_out_en    = 2;
    localparam int pos_four_pin      = 3;
    localparam int pos_gapless       = 8;
    localparam int pos_pitch         = 8;

    // ==========================================================
    // reset values and codes
    localparam logic [10:0] rate_nominal = 11'h400;
    localparam logic [1:0]  mode_normal  = 2'h1;
    localparam logic [1:0]  mode_cplm2   = 2'h3;
    localparam logic [1:0]  src_hs_osc   = 2'h2;
    localparam logic [15:0] state_idle_code = 16'h0001;
    localparam logic [15:0] state_play_code = 16'h0002;
    localparam logic [15:0] state_init_code = 16'h0000;
    localparam logic [3:0]  irq_all      = 4'hf;
    localparam logic [6:0]  pct_nominal  = 7'd100;
    localparam int          pwm_bits     = 10;

    // ==========================================================
    // timing: 15.625 khz sample rate at 50 mhz system clock
    localparam int clk_hz        = 50000000;
    localparam int sample_hz_x1000 = 15625000;
    localparam int sample_cycles =
        int'((64'(clk_hz) * 1000) / 64'(sample_hz_x1000));
    localparam int init_cycles   = 16;
    localparam int gap_samples   = 256;

    typedef enum logic [2:0] {
        proc_sleep,
        proc_init,
        proc_idle,
        proc_play,
        proc_gap
    } proc_state_e;

    typedef struct packed {
        logic pos;
        logic neg;
        logic pos_second;
        logic neg_second;
    } sound_pins_s;

endpackage

// file: design/sample_store.sv
// two-word sample memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module sample_store
#(
    parameter int width = 10
)
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             wr_en,
    input  wire logic             wr_sel,
    input  wire logic [width-1:0] wr_data,
    output logic      [width-1:0] rd_data0,
    output logic      [width-1:0] rd_data1
);
    logic [width-1:0] word0_r;
    logic [width-1:0] word1_r;
    logic [width-1:0] word0_nxt;
    logic [width-1:0] word1_nxt;

    initial
    begin
        if (width < 1 || width > 16)
            $error("sample_store width out of range");
    end

    always_comb
    begin
        word0_nxt = word0_r;
        word1_nxt = word1_r;
        if (wr_en && !wr_sel)
            word0_nxt = wr_data;
        if (wr_en && wr_sel)
            word1_nxt = wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            word0_r <= '0;
            word1_r <= '0;
        end
        else
        begin
            word0_r <= word0_nxt;
            word1_r <= word1_nxt;
        end
    end

    assign rd_data0 = word0_r;
    assign rd_data1 = word1_r;
endmodule
`default_nettype wire

// file: design/sound_pwm_output.sv
// pwm sound output stage with apb registers and a playback sequencer
//
// Overview of operation
// - samples become pwm waveforms on the sound pins for an amplifier
// - once a start command is given playback runs without software
// - one sample every 15.625 khz period drives the pwm stage
// - both channel samples are added into one output value
// - speed alone spans 75 to 125 percent in 5 percent steps
// - pitch alone spans 75 to 125 percent in 5 percent steps
// - combined: speed 85 to 115, pitch 90 to 110 percent
// - a silent gap follows each phrase unless gapless is chosen
// - four outputs, second pair in four-pin mode, low when unassigned
// - after reset pins are in two-pin mode, first combination
// - stage stops with the system clock in deep sleep
// - debug-run bit gates the stage clock while in debug mode
// - enable, 11-bit resample rate, resampler and tone enables
// - two 10-bit sample registers, one per channel
// - four write-one-to-clear flags plus an enable register
// - mode field: code 1 normal, code 3 complementary mode 2
// - processor window shows play set or check set by function
// - processor enable starts init, then idle with state code 1
`timescale 1ns/100ps
`default_nettype none
module sound_pwm_output
#(
    parameter int pwm_width = sound_pwm_pkg::pwm_bits
)
(
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       debug_mode,
    input  wire logic                       phrase_end,
    output sound_pwm_pkg::sound_pins_s      sound_pins
);
    initial
    begin
        if (pwm_width != sound_pwm_pkg::pwm_bits)
            $error("pwm_width must match the sample width");
    end

    // ==========================================================
    // register state
    logic        debug_run_r, debug_run_nxt;
    logic [1:0]  clock_source_select_r, clock_source_select_nxt;
    logic [1:0]  clock_divide_select_r, clock_divide_select_nxt;
    logic        out_en_r, out_en_nxt;
    logic [10:0] rate_r, rate_nxt;
    logic        resamp_r, resamp_nxt;
    logic        tone_r, tone_nxt;
    logic [3:0]  flags_r, flags_nxt;
    logic [3:0]  irq_en_r, irq_en_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic        pwm_on_r, pwm_on_nxt;
    logic        four_pin_r, four_pin_nxt;
    logic        proc_en_r, proc_en_nxt;
    logic        func_check_r, func_check_nxt;
    logic        gapless_r, gapless_nxt;
    logic [6:0]  speed_r, speed_nxt;
    logic [6:0]  pitch_r, pitch_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;

    logic        wr_acc;
    logic        rd_acc;
    logic        start_cmd;
    logic        stop_cmd;
    logic [9:0]  smp0;
    logic [9:0]  smp1;
    logic        sample_wr;
    logic        stage_clk_on;

    // accept a percentage only on a 5 percent step inside its window
    function automatic logic pct_ok(input logic [6:0] v,
                                    input logic [6:0] lo,
                                    input logic [6:0] hi);
        pct_ok = (v >= lo) && (v <= hi) && ((v % 7'd5) == 7'd0);
    endfunction

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign wr_acc    = psel && penable && pwrite && !pready_r;
    assign rd_acc    = psel && penable && !pwrite && !pready_r;
    assign sample_wr = wr_acc && (hit(paddr, sound_pwm_pkg::off_sample0)
                       || hit(paddr, sound_pwm_pkg::off_sample1));
    assign start_cmd = wr_acc
                       && hit(paddr, sound_pwm_pkg::off_proc_command)
                       && pwdata[0];
    assign stop_cmd  = wr_acc
                       && hit(paddr, sound_pwm_pkg::off_proc_command)
                       && pwdata[1];
    assign stage_clk_on = !debug_mode || debug_run_r;

    sample_store #(.width(10)) u_samples (
        .clk      (clk),
        .reset_n  (reset_n),
        .wr_en    (sample_wr),
        .wr_sel   (paddr[2]),
        .wr_data  (pwdata[9:0]),
        .rd_data0 (smp0),
        .rd_data1 (smp1)
    );

    // ==========================================================
    // playback sequencer
    sound_pwm_pkg::proc_state_e pst_r, pst_nxt;
    logic [19:0] pcnt_r, pcnt_nxt;
    logic        tick;
    logic [15:0] step_cycles;
    logic [6:0]  eff_speed;

    assign eff_speed = (speed_r == 7'd0) ? sound_pwm_pkg::pct_nominal
                                         : speed_r;
    assign step_cycles = 16'((32'(sound_pwm_pkg::sample_cycles) * 32'd100)
                             / 32'(eff_speed));

    always_comb
    begin
        pst_nxt  = pst_r;
        pcnt_nxt = pcnt_r;
        tick     = 1'b0;
        case (pst_r)
            sound_pwm_pkg::proc_sleep:
            begin
                pcnt_nxt = '0;
                if (proc_en_r)
                    pst_nxt = sound_pwm_pkg::proc_init;
            end
            sound_pwm_pkg::proc_init:
            begin
                pcnt_nxt = pcnt_r + 20'd1;
                if (pcnt_r == 20'(sound_pwm_pkg::init_cycles - 1))
                begin
                    pst_nxt  = sound_pwm_pkg::proc_idle;
                    pcnt_nxt = '0;
                end
            end
            sound_pwm_pkg::proc_idle:
            begin
                pcnt_nxt = '0;
                if (start_cmd)
                    pst_nxt = sound_pwm_pkg::proc_play;
            end
            sound_pwm_pkg::proc_play:
            begin
                pcnt_nxt = pcnt_r + 20'd1;
                if (pcnt_r >= 20'(step_cycles) - 20'd1)
                begin
                    pcnt_nxt = '0;
                    tick     = stage_clk_on;
                end
                if (stop_cmd)
                    pst_nxt = sound_pwm_pkg::proc_idle;
                else if (phrase_end && !gapless_r)
                begin
                    pst_nxt  = sound_pwm_pkg::proc_gap;
                    pcnt_nxt = '0;
                end
            end
            sound_pwm_pkg::proc_gap:
            begin
                pcnt_nxt = pcnt_r + 20'd1;
                if (stop_cmd)
                    pst_nxt = sound_pwm_pkg::proc_idle;
                else if (pcnt_r == 20'(sound_pwm_pkg::gap_samples
                                       * sound_pwm_pkg::sample_cycles - 1))
                begin
                    pst_nxt  = sound_pwm_pkg::proc_play;
                    pcnt_nxt = '0;
                end
            end
            default:
                pst_nxt = sound_pwm_pkg::proc_sleep;
        endcase
        if (!proc_en_r)
            pst_nxt = sound_pwm_pkg::proc_sleep;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pst_r  <= sound_pwm_pkg::proc_sleep;
            pcnt_r <= '0;
        end
        else
        begin
            pst_r  <= pst_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    // ==========================================================
    // mixer and pwm
    logic [9:0]  level_r, level_nxt;
    logic [9:0]  ramp_r, ramp_nxt;
    logic        tone_ph_r, tone_ph_nxt;
    logic        cmp;
    logic [10:0] mix_sum;
    logic        silent;
    sound_pwm_pkg::sound_pins_s pins_r, pins_nxt;

    assign mix_sum = {1'b0, smp0} + {1'b0, smp1};
    assign silent  = (pst_r == sound_pwm_pkg::proc_gap);

    always_comb
    begin
        level_nxt   = level_r;
        tone_ph_nxt = tone_ph_r;
        ramp_nxt    = stage_clk_on ? ramp_r + 10'd1 : ramp_r;
        // resampler enable gates updates on each tick; tone overrides samples
        if (tick && resamp_r)
        begin
            tone_ph_nxt = !tone_ph_r;
            if (tone_r)
                level_nxt = tone_ph_r ? 10'h3ff : 10'h000;
            else
                level_nxt = mix_sum[10] ? 10'h3ff : mix_sum[9:0];
        end
        // no tick runs in the gap, so hold mid level here
        if (silent)
            level_nxt = 10'h200;
        cmp = (ramp_r < level_r);
        pins_nxt = '0;
        if (out_en_r && pwm_on_r && stage_clk_on)
        begin
            case (mode_r)
                sound_pwm_pkg::mode_normal:
                begin
                    pins_nxt.pos = cmp;
                    pins_nxt.neg = 1'b0;
                end
                sound_pwm_pkg::mode_cplm2:
                begin
                    pins_nxt.pos = cmp;
                    pins_nxt.neg = !cmp;
                end
                default:
                begin
                    pins_nxt.pos = cmp;
                    pins_nxt.neg = cmp;
                end
            endcase
            // second pair only in four-pin mode
            if (four_pin_r)
            begin
                pins_nxt.pos_second = pins_nxt.pos;
                pins_nxt.neg_second = pins_nxt.neg;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            level_r   <= '0;
            ramp_r    <= '0;
            tone_ph_r <= 1'b0;
            pins_r    <= '0;
        end
        else
        begin
            level_r   <= level_nxt;
            ramp_r    <= ramp_nxt;
            tone_ph_r <= tone_ph_nxt;
            pins_r    <= pins_nxt;
        end
    end

    // ==========================================================
    // apb register file
    always_comb
    begin
        debug_run_nxt = debug_run_r;
        clock_source_select_nxt    = clock_source_select_r;
        clock_divide_select_nxt    = clock_divide_select_r;
        out_en_nxt    = out_en_r;
        rate_nxt      = rate_r;
        resamp_nxt    = resamp_r;
        tone_nxt      = tone_r;
        irq_en_nxt    = irq_en_r;
        mode_nxt      = mode_r;
        pwm_on_nxt    = pwm_on_r;
        four_pin_nxt  = four_pin_r;
        proc_en_nxt   = proc_en_r;
        func_check_nxt = func_check_r;
        gapless_nxt   = gapless_r;
        speed_nxt     = speed_r;
        pitch_nxt     = pitch_r;
        flags_nxt     = flags_r;
        pready_nxt    = psel && penable && !pready_r;
        pslverr_nxt   = 1'b0;
        prdata_nxt    = '0;
        // write one clears; events set, set wins
        if (wr_acc && hit(paddr, sound_pwm_pkg::off_irq_flags))
            flags_nxt = flags_r & ~pwdata[3:0];
        flags_nxt = flags_nxt | {1'b0, stop_cmd, start_cmd, tick};
        if (wr_acc)
        begin
            case (paddr)
                sound_pwm_pkg::off_clock_control:
                begin
                    debug_run_nxt = pwdata[sound_pwm_pkg::pos_debug_run];
                    clock_divide_select_nxt = pwdata[sound_pwm_pkg::pos_clock_divide_select +: 2];
                    clock_source_select_nxt = pwdata[sound_pwm_pkg::pos_clock_source_select +: 2];
                end
                sound_pwm_pkg::off_control:
                begin
                    out_en_nxt = pwdata[sound_pwm_pkg::pos_output_enable];
                    rate_nxt   = pwdata[sound_pwm_pkg::pos_rate +: 11];
                    resamp_nxt = pwdata[sound_pwm_pkg::pos_resamp_en];
                    tone_nxt   = pwdata[sound_pwm_pkg::pos_tone_on];
                end
                sound_pwm_pkg::off_irq_enable:
                    irq_en_nxt = pwdata[3:0];
                sound_pwm_pkg::off_mode:
                begin
                    mode_nxt     = pwdata[1:0];
                    pwm_on_nxt   = pwdata[sound_pwm_pkg::pos_pwm_out_en];
                    four_pin_nxt = pwdata[sound_pwm_pkg::pos_four_pin];
                end
                sound_pwm_pkg::off_proc_control:
                begin
                    proc_en_nxt    = pwdata[0];
                    func_check_nxt = pwdata[1];
                end
                sound_pwm_pkg::off_proc_command:
                    gapless_nxt = pwdata[sound_pwm_pkg::pos_gapless];
                sound_pwm_pkg::off_speed_pitch:
                begin
                    if (pst_r != sound_pwm_pkg::proc_play)
                    begin
                        if (pwdata[6:0] == sound_pwm_pkg::pct_nominal
                            || pwdata[14:8] == sound_pwm_pkg::pct_nominal)
                        begin
                            if (pct_ok(pwdata[6:0], 7'd75, 7'd125)
                                && pct_ok(pwdata[14:8], 7'd75, 7'd125))
                            begin
                                speed_nxt = pwdata[6:0];
                                pitch_nxt = pwdata[14:8];
                            end
                        end
                        else if (pct_ok(pwdata[6:0], 7'd85, 7'd115)
                                 && pct_ok(pwdata[14:8], 7'd90, 7'd110))
                        begin
                            speed_nxt = pwdata[6:0];
                            pitch_nxt = pwdata[14:8];
                        end
                    end
                end
                default:
                    ;
            endcase
        end
        if (rd_acc)
        begin
            case (paddr)
                sound_pwm_pkg::off_clock_control:
                    prdata_nxt = {23'h0, debug_run_r, 2'h0, clock_divide_select_r,
                                  2'h0, clock_source_select_r};
                sound_pwm_pkg::off_control:
                    prdata_nxt = {18'h0, tone_r, resamp_r, rate_r, out_en_r};
                sound_pwm_pkg::off_sample0:
                    prdata_nxt = {22'h0, smp0};
                sound_pwm_pkg::off_sample1:
                    prdata_nxt = {22'h0, smp1};
                sound_pwm_pkg::off_irq_flags:
                    prdata_nxt = {28'h0, flags_r};
                sound_pwm_pkg::off_irq_enable:
                    prdata_nxt = {28'h0, irq_en_r};
                sound_pwm_pkg::off_mode:
                    prdata_nxt = {28'h0, four_pin_r, pwm_on_r, mode_r};
                sound_pwm_pkg::off_proc_control:
                    prdata_nxt = {30'h0, func_check_r, proc_en_r};
                sound_pwm_pkg::off_proc_command:
                    prdata_nxt = {23'h0, gapless_r, 8'h0};
                sound_pwm_pkg::off_proc_state:
                    if (func_check_r)
                        prdata_nxt = 32'h0;
                    else if (pst_r == sound_pwm_pkg::proc_idle)
                        prdata_nxt = {16'h0, sound_pwm_pkg::state_idle_code};
                    else if (pst_r == sound_pwm_pkg::proc_play
                             || pst_r == sound_pwm_pkg::proc_gap)
                        prdata_nxt = {16'h0, sound_pwm_pkg::state_play_code};
                    else
                        prdata_nxt = {16'h0, sound_pwm_pkg::state_init_code};
                sound_pwm_pkg::off_speed_pitch:
                    prdata_nxt = {17'h0, pitch_r, 1'b0, speed_r};
                default:
                    pslverr_nxt = 1'b1;
            endcase
        end
        if (wr_acc && paddr > sound_pwm_pkg::off_speed_pitch)
            pslverr_nxt = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            debug_run_r  <= 1'b1;
            clock_source_select_r     <= 2'h0;
            clock_divide_select_r     <= 2'h0;
            out_en_r     <= 1'b0;
            rate_r       <= sound_pwm_pkg::rate_nominal;
            resamp_r     <= 1'b0;
            tone_r       <= 1'b0;
            flags_r      <= 4'h0;
            irq_en_r     <= 4'h0;
            mode_r       <= sound_pwm_pkg::mode_normal;
            pwm_on_r     <= 1'b0;
            four_pin_r   <= 1'b0;
            proc_en_r    <= 1'b0;
            func_check_r <= 1'b0;
            gapless_r    <= 1'b0;
            speed_r      <= sound_pwm_pkg::pct_nominal;
            pitch_r      <= sound_pwm_pkg::pct_nominal;
            prdata_r     <= '0;
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
        end
        else
        begin
            debug_run_r  <= debug_run_nxt;
            clock_source_select_r     <= clock_source_select_nxt;
            clock_divide_select_r     <= clock_divide_select_nxt;
            out_en_r     <= out_en_nxt;
            rate_r       <= rate_nxt;
            resamp_r     <= resamp_nxt;
            tone_r       <= tone_nxt;
            flags_r      <= flags_nxt;
            irq_en_r     <= irq_en_nxt;
            mode_r       <= mode_nxt;
            pwm_on_r     <= pwm_on_nxt;
            four_pin_r   <= four_pin_nxt;
            proc_en_r    <= proc_en_nxt;
            func_check_r <= func_check_nxt;
            gapless_r    <= gapless_nxt;
            speed_r      <= speed_nxt;
            pitch_r      <= pitch_nxt;
            prdata_r     <= prdata_nxt;
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
        end
    end

    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign sound_pins = pins_r;
endmodule
`default_nettype wire

// file: sim/amp_model.sv
// amplifier model: integrates high time of the pos and neg pwm pins
`timescale 1ns/100ps
`default_nettype none
module amp_model
(
    input  wire logic                       clk,
    input  wire logic                       clr,
    input  wire sound_pwm_pkg::sound_pins_s pins,
    output int                              pos_n,
    output int                              neg_n
);
    // a counter per pin of the first pair stands in for the amplifier's low-pass filter
    always_ff @(posedge clk)
    begin
        pos_n <= clr ? 0 : pos_n + int'(pins.pos);
        neg_n <= clr ? 0 : neg_n + int'(pins.neg);
    end
endmodule
`default_nettype wire

// file: sim/sound_pwm_assertions.sv
// concurrent checks on the bus port and pins of the sound stage
`timescale 1ns/100ps
`default_nettype none
module sound_pwm_assertions
(
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [7:0]                 paddr,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire sound_pwm_pkg::sound_pins_s sound_pins
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic acc = psel && penable && !pready;
    wire logic scnd = sound_pins.pos_second || sound_pins.neg_second;
    ready_after_access_a: assert property (acc |=> pready)
        else $error("no ready after access");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_refused_a: assert property (
        acc && paddr > 8'h28 |=> pslverr)
        else $error("unmapped access not refused");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    second_pair_a: assert property (
        scnd |-> sound_pins[3:2] == sound_pins[1:0])
        else $error("second pair differs from first");
    pins_reset_a: assert property (
        $rose(reset_n) |-> sound_pins == 4'h0)
        else $error("pins not low after reset");
    pos_ready_a: assert property (pready |-> $past(acc))
        else $error("ready without access");
    cover property (pready && !pslverr);
    cover property (pslverr);
    cover property (sound_pins.pos && sound_pins.pos_second);
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the pwm sound stage
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, debug_mode = 1'b0, phrase_end = 1'b0;
    logic        clr = 1'b1, pready, pslverr, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          pos_n, neg_n, fail_count = 0, n_tests = 0;
    sound_pwm_pkg::sound_pins_s pins;
    always #10 clk = ~clk;
    sound_pwm_output i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_mode(debug_mode), .phrase_end(phrase_end), .sound_pins(pins));
    amp_model i_amp (.clk(clk), .clr(clr), .pins(pins), .pos_n(pos_n),
        .neg_n(neg_n));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // request held from setup until ready is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // a free 10-bit ramp gives exactly level high cycles per 1024
    task automatic measure(input int p, input int q);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (1024) @(posedge clk);
        #1;
        chk(32'(pos_n), 32'(p));
        chk(32'(neg_n), 32'(q));
        $display("test done at %0t", $time);
        @(posedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #2000000;
        fail_count++;
        complete_run;
    end
    // ==========================================================
    // test sequence
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rc(8'h00, 32'h100);
        rc(8'h04, 32'h800);
        rc(8'h18, 32'h1);
        bus(1'b1, 8'h2c, 32'h1);
        chk({31'h0, err}, 32'h1);
        bus(1'b1, 8'h08, 32'hffffffff);
        rc(8'h08, 32'h3ff);
        bus(1'b1, 8'h10, 32'hf);
        rc(8'h10, 32'h0);
        bus(1'b1, 8'h14, 32'hf);
        rc(8'h14, 32'hf);
        bus(1'b1, 8'h28, 32'h647d);
        rc(8'h28, 32'h647d);
        bus(1'b1, 8'h28, 32'h7d64);
        rc(8'h28, 32'h7d64);
        bus(1'b1, 8'h28, 32'h6e73);
        bus(1'b1, 8'h28, 32'h7d73);
        rc(8'h28, 32'h6e73);
        bus(1'b1, 8'h28, 32'h6464);
        // stage set up before the processor starts
        bus(1'b1, 8'h08, 32'h100);
        bus(1'b1, 8'h0c, 32'h80);
        bus(1'b1, 8'h04, 32'h1801);
        bus(1'b1, 8'h18, 32'h5);
        bus(1'b1, 8'h1c, 32'h1);
        rc(8'h24, 32'h0);
        repeat (20) @(posedge clk);
        rc(8'h24, 32'h1);
        bus(1'b1, 8'h20, 32'h1);
        rc(8'h24, 32'h2);
        rc(8'h10, 32'h2);
        bus(1'b1, 8'h10, 32'h2);
        rc(8'h10, 32'h0);
        repeat (3300) @(posedge clk);
        measure(384, 0);
        bus(1'b1, 8'h18, 32'hf);
        measure(384, 640);
        phrase_end <= 1'b1;
        @(posedge clk);
        phrase_end <= 1'b0;
        repeat (3300) @(posedge clk);
        measure(512, 512);
        bus(1'b1, 8'h00, 32'h2);
        debug_mode <= 1'b1;
        measure(0, 0);
        debug_mode <= 1'b0;
        bus(1'b1, 8'h04, 32'h1800);
        measure(0, 0);
        bus(1'b1, 8'h1c, 32'h3);
        rc(8'h24, 32'h0);
        complete_run;
    end
endmodule
bind sound_pwm_output sound_pwm_assertions i_chk (.clk(clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sound_pins(sound_pins));
`default_nettype wire
